/* File: pkg/mac_filt_pkg.sv */
package mac_filt_pkg;

  // ----------------------------------------
  // Register indices on the indirect CSR port
  // ----------------------------------------
  localparam logic [3:0] IDX_MAC_CONTROL = 4'h1;
  localparam logic [3:0] IDX_ADDR_HIGH   = 4'h2;
  localparam logic [3:0] IDX_ADDR_LOW    = 4'h3;
  localparam logic [3:0] IDX_HASH_HIGH   = 4'h4;
  localparam logic [3:0] IDX_HASH_LOW    = 4'h5;

  // ----------------------------------------
  // mac_control field positions
  // ----------------------------------------
  localparam int HASH_ONLY_BIT      = 15;
  localparam int HASH_FILTER_BIT    = 13;
  localparam int LATE_RETRY_BIT     = 12;
  localparam int BROADCAST_BLOCK_BLOCK_BIT    = 11;
  localparam int SINGLE_ATTEMPT_BIT = 10;
  localparam int PAD_STRIP_BIT      = 8;

  // ----------------------------------------
  // Reset values and writable bits
  // ----------------------------------------
  localparam logic [31:0] MAC_CONTROL_RESET = 32'h0004_0000;
  localparam logic [31:0] MAC_CONTROL_WMASK = 32'h80bf_bdff; // Bit 9 and reserved bits excluded
  localparam logic [31:0] ADDR_HIGH_RESET   = 32'h0000_ffff;
  localparam logic [31:0] ADDR_HIGH_WMASK   = 32'h0000_ffff;
  localparam logic [31:0] ADDR_LOW_RESET    = 32'hffff_ffff;
  localparam logic [31:0] HASH_RESET        = 32'h0000_0000;

  // ----------------------------------------
  // Frame and retry counts
  // ----------------------------------------
  localparam logic [4:0]  MAX_ATTEMPTS  = 5'd16;
  localparam logic [15:0] LEN_FIELD_MIN = 16'd46;
  localparam logic [15:0] HEADER_BYTES  = 16'd14;
  localparam logic [15:0] LEN_HI_POS    = 16'd12;
  localparam logic [15:0] LEN_LO_POS    = 16'd13;
  localparam logic [47:0] BROADCAST_BLOCK_ADDR    = 48'hffff_ffff_ffff;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic late_collision;
    logic retry_error;
  } tx_status_s;

  typedef struct packed {
    logic accept;
    logic reject;
    logic wake;
  } rx_verdict_s;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } tx_state_e;

endpackage

/* File: rtl/hash_table_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module hash_table_mem
  import mac_filt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Write port
  input  wire logic        we,
  input  wire logic        waddr,
  input  wire logic [31:0] wdata,
  // Registered read ports
  input  wire logic        ra_addr,
  output logic      [31:0] ra_data,
  input  wire logic        rb_addr,
  output logic      [31:0] rb_data
);

  logic [31:0] mem [2];
  logic [31:0] next_mem [2];

  // ----------------------------------------
  // Storage update
  // ----------------------------------------
  always_comb begin
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    if (we) begin
      next_mem[waddr] = wdata;
    end
  end

  // Read data always come out of a register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem[0]  <= HASH_RESET;
      mem[1]  <= HASH_RESET;
      ra_data <= HASH_RESET;
      rb_data <= HASH_RESET;
    end else begin
      mem[0]  <= next_mem[0];
      mem[1]  <= next_mem[1];
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
    end
  end

endmodule // hash_table_mem
`default_nettype wire

/* File: rtl/mac_filter_retry_pad_control.sv */
`timescale 1ns/100ps
`default_nettype none
module mac_filter_retry_pad_control
  import mac_filt_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_I,
  // Indirect CSR port
  input  wire logic [3:0]  CSR_INDEX_I,
  input  wire logic [31:0] CSR_WDATA_I,
  input  wire logic        CSR_WR_I,
  input  wire logic        CSR_RD_I,
  output logic      [31:0] CSR_RDATA_O,
  output logic             CSR_ACK_O,
  // Neighbouring control bits
  input  wire logic        WAKEUP_FRAME_ENABLE_I,
  input  wire logic        RX_CHECKSUM_OFFLOAD_ON_I,
  output logic             CFG_CONFLICT_O,
  // Destination address check
  input  wire logic        RX_DA_VALID_I,
  input  wire logic [47:0] RX_DA_I,
  input  wire logic [5:0]  RX_HASH_I,
  input  wire logic        RX_WAKE_FRAME_I,
  output logic             RX_ACCEPT_O,
  output logic             RX_REJECT_O,
  output logic             WAKE_O,
  // Receive byte stream in
  input  wire logic        RX_BYTE_VALID_I,
  input  wire logic [7:0]  RX_BYTE_I,
  input  wire logic        RX_SOF_I,
  input  wire logic        RX_EOF_I,
  // Receive byte stream out
  output logic             RX_OUT_VALID_O,
  output logic      [7:0]  RX_OUT_DATA_O,
  output logic             RX_OUT_SOF_O,
  output logic             RX_OUT_EOF_O,
  // Transmit attempt events
  input  wire logic        TX_START_I,
  input  wire logic        TX_COLLISION_I,
  input  wire logic        TX_LATE_I,
  input  wire logic        TX_DONE_I,
  output logic             TX_RETRY_O,
  output logic             TX_ABANDON_O,
  output logic             TX_STATUS_VALID_O,
  output logic      [1:0]  TX_STATUS_O
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Station address bytes in wire order, first byte in the top
  function automatic logic [47:0] station_addr(input logic [31:0] lo, input logic [31:0] hi);
    return {lo[7:0], lo[15:8], lo[23:16], lo[31:24], hi[7:0], hi[15:8]};
  endfunction

  logic [31:0] mac_control;
  logic [31:0] addr_high;
  logic [31:0] addr_low;
  logic        hash_only_select;
  logic        hash_filter_select;
  logic        late_collision_retry;
  logic        broadcast_block;
  logic        single_attempt_select;
  logic        pad_strip_enable;

  assign hash_only_select      = mac_control[HASH_ONLY_BIT];
  assign hash_filter_select    = mac_control[HASH_FILTER_BIT];
  assign late_collision_retry  = mac_control[LATE_RETRY_BIT];
  assign broadcast_block       = mac_control[BROADCAST_BLOCK_BLOCK_BIT];
  assign single_attempt_select = mac_control[SINGLE_ATTEMPT_BIT];
  assign pad_strip_enable      = mac_control[PAD_STRIP_BIT];

  // ----------------------------------------
  // Hash table storage
  // ----------------------------------------
  logic        hash_we;
  logic [31:0] hash_word_filter;
  logic [31:0] hash_word_csr;

  assign hash_we = CSR_WR_I && (CSR_INDEX_I == IDX_HASH_HIGH || CSR_INDEX_I == IDX_HASH_LOW);

  hash_table_mem u_hash (
    .clk     (CORE_CLK_I),
    .rst     (RST_I),
    .we      (hash_we),
    .waddr   (CSR_INDEX_I == IDX_HASH_HIGH),
    .wdata   (CSR_WDATA_I),
    .ra_addr (RX_HASH_I[5]),
    .ra_data (hash_word_filter),
    .rb_addr (CSR_INDEX_I == IDX_HASH_HIGH),
    .rb_data (hash_word_csr)
  );

  // ----------------------------------------
  // CSR port
  // ----------------------------------------
  logic        rd_pend;
  logic [3:0]  rd_idx;
  logic        conflict;
  logic [31:0] next_mac_control;
  logic [31:0] next_addr_high;
  logic [31:0] next_addr_low;
  logic        next_rd_pend;
  logic [3:0]  next_rd_idx;
  logic [31:0] next_rdata;
  logic        next_conflict;

  // Writes land at once; reads wait one edge for the registered hash word
  always_comb begin
    next_mac_control = mac_control;
    next_addr_high   = addr_high;
    next_addr_low    = addr_low;
    next_rd_pend     = CSR_RD_I;
    next_rd_idx      = CSR_RD_I ? CSR_INDEX_I : rd_idx;
    next_rdata       = CSR_RDATA_O;
    if (CSR_WR_I) begin
      case (CSR_INDEX_I)
        IDX_MAC_CONTROL: next_mac_control = CSR_WDATA_I & MAC_CONTROL_WMASK;
        IDX_ADDR_HIGH:   next_addr_high   = CSR_WDATA_I & ADDR_HIGH_WMASK;
        IDX_ADDR_LOW:    next_addr_low    = CSR_WDATA_I;
        default:         next_addr_low    = addr_low;
      endcase
    end
    if (rd_pend) begin
      case (rd_idx)
        IDX_MAC_CONTROL: next_rdata = mac_control;
        IDX_ADDR_HIGH:   next_rdata = addr_high;
        IDX_ADDR_LOW:    next_rdata = addr_low;
        IDX_HASH_HIGH:   next_rdata = hash_word_csr;
        IDX_HASH_LOW:    next_rdata = hash_word_csr;
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
    // Flag the combination software must never program
    next_conflict = pad_strip_enable && RX_CHECKSUM_OFFLOAD_ON_I;
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mac_control    <= MAC_CONTROL_RESET;
      addr_high      <= ADDR_HIGH_RESET;
      addr_low       <= ADDR_LOW_RESET;
      rd_pend        <= 1'b0;
      rd_idx         <= 4'h0;
      CSR_RDATA_O    <= 32'h0000_0000;
      CSR_ACK_O      <= 1'b0;
      conflict       <= 1'b0;
      CFG_CONFLICT_O <= 1'b0;
    end else begin
      mac_control    <= next_mac_control;
      addr_high      <= next_addr_high;
      addr_low       <= next_addr_low;
      rd_pend        <= next_rd_pend;
      rd_idx         <= next_rd_idx;
      CSR_RDATA_O    <= next_rdata;
      CSR_ACK_O      <= rd_pend;
      conflict       <= next_conflict;
      CFG_CONFLICT_O <= conflict;
    end
  end

  // ----------------------------------------
  // Destination address filter
  // ----------------------------------------
  logic        flt_valid;
  logic        flt_broadcast_block;
  logic        flt_use_hash;
  logic        flt_perfect;
  logic        flt_wake;
  logic [4:0]  flt_bit;
  logic        next_flt_broadcast_block;
  logic        next_flt_use_hash;
  logic        next_flt_perfect;
  rx_verdict_s next_verdict;

  // Stage one samples the address while the hash word is fetched
  always_comb begin
    next_flt_broadcast_block    = (RX_DA_I == BROADCAST_BLOCK_ADDR);
    next_flt_perfect  = (RX_DA_I == station_addr(addr_low, addr_high));
    // Multicast uses the hash with either select; individual only with hash-only
    next_flt_use_hash = hash_only_select
                      || (hash_filter_select && RX_DA_I[40]);
    next_verdict      = '0;
    if (flt_valid) begin
      if (flt_broadcast_block) begin
        next_verdict.accept = !broadcast_block;
      end else if (flt_use_hash) begin
        next_verdict.accept = hash_word_filter[flt_bit];
      end else begin
        next_verdict.accept = flt_perfect;
      end
      next_verdict.reject = !next_verdict.accept;
      // Wake decision ignores the broadcast block on purpose
      next_verdict.wake   = flt_wake && WAKEUP_FRAME_ENABLE_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flt_valid    <= 1'b0;
      flt_broadcast_block    <= 1'b0;
      flt_use_hash <= 1'b0;
      flt_perfect  <= 1'b0;
      flt_wake     <= 1'b0;
      flt_bit      <= 5'h00;
      RX_ACCEPT_O  <= 1'b0;
      RX_REJECT_O  <= 1'b0;
      WAKE_O       <= 1'b0;
    end else begin
      flt_valid    <= RX_DA_VALID_I;
      flt_broadcast_block    <= next_flt_broadcast_block;
      flt_use_hash <= next_flt_use_hash;
      flt_perfect  <= next_flt_perfect;
      flt_wake     <= RX_WAKE_FRAME_I;
      flt_bit      <= RX_HASH_I[4:0];
      RX_ACCEPT_O  <= next_verdict.accept;
      RX_REJECT_O  <= next_verdict.reject;
      WAKE_O       <= next_verdict.wake;
    end
  end

  // ----------------------------------------
  // Pad and FCS stripping
  // ----------------------------------------
  logic [15:0] byte_pos;
  logic [7:0]  len_hi;
  logic [15:0] len_field;
  logic        strip;
  logic [15:0] cur_pos;
  logic [15:0] next_byte_pos;
  logic [7:0]  next_len_hi;
  logic [15:0] next_len_field;
  logic        next_strip;
  logic        keep;

  // Length field is known before the payload, so no frame buffer is needed
  always_comb begin
    cur_pos        = RX_SOF_I ? 16'h0000 : byte_pos;
    next_byte_pos  = byte_pos;
    next_len_hi    = len_hi;
    next_len_field = len_field;
    next_strip     = RX_SOF_I ? 1'b0 : strip;
    keep           = 1'b1;
    if (RX_BYTE_VALID_I) begin
      next_byte_pos = (cur_pos == 16'hffff) ? cur_pos : cur_pos + 16'h0001;
      if (cur_pos == LEN_HI_POS) begin
        next_len_hi = RX_BYTE_I;
      end
      if (cur_pos == LEN_LO_POS) begin
        next_len_field = {len_hi, RX_BYTE_I};
        // Type values and long lengths leave the frame untouched
        next_strip = pad_strip_enable && ({len_hi, RX_BYTE_I} < LEN_FIELD_MIN);
      end
      // Pad and FCS: all past header plus length
      if (strip && cur_pos >= HEADER_BYTES + len_field) begin
        keep = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      byte_pos       <= 16'h0000;
      len_hi         <= 8'h00;
      len_field      <= 16'h0000;
      strip          <= 1'b0;
      RX_OUT_VALID_O <= 1'b0;
      RX_OUT_DATA_O  <= 8'h00;
      RX_OUT_SOF_O   <= 1'b0;
      RX_OUT_EOF_O   <= 1'b0;
    end else begin
      byte_pos       <= next_byte_pos;
      len_hi         <= next_len_hi;
      len_field      <= next_len_field;
      strip          <= next_strip;
      RX_OUT_VALID_O <= RX_BYTE_VALID_I && keep;
      RX_OUT_DATA_O  <= RX_BYTE_I;
      RX_OUT_SOF_O   <= RX_BYTE_VALID_I && RX_SOF_I;
      RX_OUT_EOF_O   <= RX_BYTE_VALID_I && RX_EOF_I; // End mark survives a stripped tail
    end
  end

  // ----------------------------------------
  // Transmit retry policy
  // ----------------------------------------
  tx_state_e  tx_state;
  tx_state_e  next_tx_state;
  logic [4:0] attempts;
  logic [4:0] next_attempts;
  logic       late_seen;
  logic       next_late_seen;
  logic       next_retry;
  logic       next_abandon;
  logic       next_stat_valid;
  tx_status_s next_status;

  always_comb begin
    next_tx_state   = tx_state;
    next_attempts   = attempts;
    next_late_seen  = late_seen;
    next_retry      = 1'b0;
    next_abandon    = 1'b0;
    next_stat_valid = 1'b0;
    next_status     = TX_STATUS_O;
    case (tx_state)
      TX_IDLE: begin
        if (TX_START_I) begin
          next_tx_state  = TX_BUSY;
          next_attempts  = 5'd1;
          next_late_seen = 1'b0;
        end
      end
      TX_BUSY: begin
        if (TX_COLLISION_I) begin
          next_late_seen              = late_seen || TX_LATE_I;
          next_status.late_collision  = late_seen || TX_LATE_I;
          next_status.retry_error     = 1'b0;
          if (TX_LATE_I && !late_collision_retry) begin
            next_abandon    = 1'b1;
            next_stat_valid = 1'b1;
            next_tx_state   = TX_IDLE;
          end else if (single_attempt_select || attempts >= MAX_ATTEMPTS) begin
            next_abandon            = 1'b1;
            next_stat_valid         = 1'b1;
            next_status.retry_error = 1'b1;
            next_tx_state           = TX_IDLE;
          end else begin
            // Retry counts the next attempt; late ones too when allowed
            next_retry    = 1'b1;
            next_attempts = attempts + 5'd1;
          end
        end else if (TX_DONE_I) begin
          next_stat_valid            = 1'b1;
          next_status.late_collision = late_seen;
          next_status.retry_error    = 1'b0;
          next_tx_state              = TX_IDLE;
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_state          <= TX_IDLE;
      attempts          <= 5'd0;
      late_seen         <= 1'b0;
      TX_RETRY_O        <= 1'b0;
      TX_ABANDON_O      <= 1'b0;
      TX_STATUS_VALID_O <= 1'b0;
      TX_STATUS_O       <= 2'b00;
    end else begin
      tx_state          <= next_tx_state;
      attempts          <= next_attempts;
      late_seen         <= next_late_seen;
      TX_RETRY_O        <= next_retry;
      TX_ABANDON_O      <= next_abandon;
      TX_STATUS_VALID_O <= next_stat_valid;
      TX_STATUS_O       <= next_status;
    end
  end

endmodule // mac_filter_retry_pad_control
`default_nettype wire

/* File: verif/mac_filter_retry_pad_control_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module mac_filter_checker
  import mac_filt_pkg::*;
(
  // Clock, reset and CSR port
  input wire logic        CORE_CLK_I,
  input wire logic        RST_I,
  input wire logic [3:0]  CSR_INDEX_I,
  input wire logic [31:0] CSR_WDATA_I,
  input wire logic        CSR_WR_I,
  input wire logic [31:0] CSR_RDATA_O,
  input wire logic        CSR_ACK_O,
  // Address filter
  input wire logic        WAKEUP_FRAME_ENABLE_I,
  input wire logic        RX_DA_VALID_I,
  input wire logic [47:0] RX_DA_I,
  input wire logic        RX_WAKE_FRAME_I,
  input wire logic        RX_ACCEPT_O,
  input wire logic        RX_REJECT_O,
  input wire logic        WAKE_O,
  // Byte stream and transmit
  input wire logic        RX_BYTE_VALID_I,
  input wire logic [7:0]  RX_BYTE_I,
  input wire logic        RX_OUT_VALID_O,
  input wire logic [7:0]  RX_OUT_DATA_O,
  input wire logic        RX_OUT_EOF_O,
  input wire logic        TX_LATE_I,
  input wire logic        TX_RETRY_O,
  input wire logic        TX_ABANDON_O,
  input wire logic [1:0]  TX_STATUS_O
);
  // ----------------------------------------
  // Shadow of the programmed setup
  // ----------------------------------------
  logic [31:0] ctl, next_ctl, ah, next_ah, al, next_al;
  logic [47:0] sta;
  logic        bc, hit;
  assign sta = {<<8{ah[15:0], al}};
  assign bc  = RX_DA_I == BROADCAST_BLOCK_ADDR;
  assign hit = RX_DA_I == sta;
  // Shadow tracks CSR writes as the design does
  always_comb begin
    next_ctl = ctl;
    next_ah = ah;
    next_al = al;
    if (CSR_WR_I && CSR_INDEX_I == IDX_MAC_CONTROL) next_ctl = CSR_WDATA_I & MAC_CONTROL_WMASK;
    if (CSR_WR_I && CSR_INDEX_I == IDX_ADDR_HIGH) next_ah = CSR_WDATA_I & ADDR_HIGH_WMASK;
    if (CSR_WR_I && CSR_INDEX_I == IDX_ADDR_LOW) next_al = CSR_WDATA_I;
  end
  // Registers the shadow
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctl <= MAC_CONTROL_RESET;
      ah <= ADDR_HIGH_RESET;
      al <= ADDR_LOW_RESET;
    end else begin
      ctl <= next_ctl;
      ah <= next_ah;
      al <= next_al;
    end
  end
  default clocking dc @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  property p_exact;
    RX_DA_VALID_I && !ctl[HASH_FILTER_BIT] && !ctl[HASH_ONLY_BIT] && !bc
      |-> ##2 RX_ACCEPT_O == $past(hit, 2);
  endproperty
  a_exact: assert property (p_exact) else $error("exact match verdict wrong");
  property p_broadcast_block;
    RX_DA_VALID_I && bc && ctl[BROADCAST_BLOCK_BLOCK_BIT] |-> ##2 RX_REJECT_O && !RX_ACCEPT_O;
  endproperty
  a_broadcast_block: assert property (p_broadcast_block) else $error("blocked broadcast passed");
  property p_broadcast_block_pass;
    RX_DA_VALID_I && bc && !ctl[BROADCAST_BLOCK_BLOCK_BIT] |-> ##2 RX_ACCEPT_O;
  endproperty
  a_broadcast_block_pass: assert property (p_broadcast_block_pass) else $error("broadcast dropped");
  property p_wake;
    RX_DA_VALID_I && RX_WAKE_FRAME_I && WAKEUP_FRAME_ENABLE_I |-> ##2 WAKE_O;
  endproperty
  a_wake: assert property (p_wake) else $error("wake frame missed");
  property p_late_retry;
    TX_RETRY_O && $past(TX_LATE_I) |-> ctl[LATE_RETRY_BIT];
  endproperty
  a_late_retry: assert property (p_late_retry) else $error("late retry when off");
  property p_late_flag;
    TX_ABANDON_O && $past(TX_LATE_I) |-> TX_STATUS_O[1];
  endproperty
  a_late_flag: assert property (p_late_flag) else $error("late flag not set");
  property p_single;
    TX_RETRY_O |-> !ctl[SINGLE_ATTEMPT_BIT];
  endproperty
  a_single: assert property (p_single) else $error("retry in single attempt");
  property p_pad_off;
    RX_BYTE_VALID_I && !ctl[PAD_STRIP_BIT] |=> RX_OUT_VALID_O && RX_OUT_DATA_O == $past(RX_BYTE_I);
  endproperty
  a_pad_off: assert property (p_pad_off) else $error("byte altered");
  property p_rd_zero;
    CSR_ACK_O && $past(CSR_INDEX_I, 2) == IDX_MAC_CONTROL |-> !CSR_RDATA_O[9];
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("reserved bit reads one");
  c_bc_rej: cover property (RX_DA_VALID_I && bc ##2 RX_REJECT_O);
  c_abandon: cover property (TX_ABANDON_O && TX_STATUS_O[0]);
  c_strip: cover property (RX_OUT_EOF_O && !RX_OUT_VALID_O);
endmodule // mac_filter_checker
bind mac_filter_retry_pad_control mac_filter_checker mac_filter_checker_i (.*);
`default_nettype wire

/* File: verif/phy_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
module phy_rx_model (
  // Control from the bench
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [15:0] len,
  input  wire logic [7:0]  total,
  // Receive bytes towards the MAC
  output logic             vld,
  output logic      [7:0]  data,
  output logic             sof,
  output logic             eof,
  output logic             busy
);
  // ----------------------------------------
  // Frame source with one idle gap
  // ----------------------------------------
  int   i = 0;
  logic gap = 1'b0;
  logic start;
  initial {vld, data, sof, eof, busy} = '0;
  // Idle data inverts the previous value each cycle, so every second idle cycle repeats the last byte
  always @(posedge clk) begin
    start = go & ~busy;
    #1;
    if (start) busy = 1'b1;
    if (start) i = 0;
    gap = busy && i == 20 && !gap;
    if (busy && !gap) begin
      vld = 1'b1;
      data = (i == 12) ? len[15:8] : (i == 13) ? len[7:0] : i[7:0] ^ 8'h5a;
      sof = i == 0;
      eof = i == total - 1;
      i++;
      if (i == total) busy = 1'b0;
    end else begin
      vld = 1'b0;
      data = ~data;
      sof = 1'b0;
      eof = 1'b0;
    end
  end
endmodule // phy_rx_model
`default_nettype wire

/* File: verif/test_mac_filter_retry_pad_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_mac_filter_retry_pad_control
  import mac_filt_pkg::*;
;
  logic        CORE_CLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic [3:0]  CSR_INDEX_I;
  logic [31:0] CSR_WDATA_I, CSR_RDATA_O, ctl_m, al, ah, r;
  logic        CSR_WR_I, CSR_RD_I, CSR_ACK_O, WAKEUP_FRAME_ENABLE_I, RX_CHECKSUM_OFFLOAD_ON_I;
  logic        CFG_CONFLICT_O, RX_DA_VALID_I, RX_WAKE_FRAME_I, RX_ACCEPT_O, RX_REJECT_O;
  logic        WAKE_O, RX_BYTE_VALID_I, RX_SOF_I, RX_EOF_I, RX_OUT_VALID_O, RX_OUT_SOF_O;
  logic        RX_OUT_EOF_O, TX_START_I, TX_COLLISION_I, TX_LATE_I, TX_DONE_I, TX_RETRY_O;
  logic        TX_ABANDON_O, TX_STATUS_VALID_O, go = 1'b0, busy;
  logic [47:0] RX_DA_I, sta, da;
  logic [5:0]  RX_HASH_I;
  logic [7:0]  RX_BYTE_I, RX_OUT_DATA_O, ftot, in_q[$], out_q[$];
  logic [1:0]  TX_STATUS_O;
  logic [15:0] flen;
  logic [63:0] htab;
  int          mismatches = 0, tests_run = 0, eofs = 0, sofs = 0, m, j;
  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  always #10 CORE_CLK_I = ~CORE_CLK_I;
  mac_filter_retry_pad_control mac_filter_retry_pad_control_i (.*);
  phy_rx_model phy_rx_model_i (.clk(CORE_CLK_I), .go(go), .len(flen), .total(ftot),
    .vld(RX_BYTE_VALID_I), .data(RX_BYTE_I), .sof(RX_SOF_I), .eof(RX_EOF_I), .busy(busy));
  // Stream monitors feed the frame model
  always @(posedge CORE_CLK_I) begin
    if (RX_BYTE_VALID_I) in_q.push_back(RX_BYTE_I);
    if (RX_OUT_VALID_O) out_q.push_back(RX_OUT_DATA_O);
    if (RX_OUT_EOF_O) eofs++;
    if (RX_OUT_SOF_O) sofs++;
  end
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge CORE_CLK_I);
    #1;
  endtask
  task automatic chk(input logic ok, input string s);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, s);
    end
  endtask
  task automatic csr_wr(input logic [3:0] i, input logic [31:0] d);
    CSR_INDEX_I = i;
    CSR_WDATA_I = d;
    CSR_WR_I = 1'b1;
    tick;
    CSR_WR_I = 1'b0;
    tick;
  endtask
  // Bounded wait for the read answer
  task automatic csr_rd(input logic [3:0] i, input logic [31:0] e);
    int n;
    CSR_INDEX_I = i;
    CSR_RD_I = 1'b1;
    tick;
    CSR_RD_I = 1'b0;
    for (n = 0; n < 4 && CSR_ACK_O !== 1'b1; n++) tick;
    chk(CSR_ACK_O === 1'b1 && CSR_RDATA_O === e, "csr read");
  endtask
  task automatic set_ctl(input logic [31:0] v);
    csr_wr(IDX_MAC_CONTROL, v);
    ctl_m = v & MAC_CONTROL_WMASK;
  endtask
  // Filter model: broadcast first, then hash or exact match
  task automatic da_chk(input logic [47:0] d, input logic [5:0] h, input logic wk, input logic we);
    logic a;
    if (d == BROADCAST_BLOCK_ADDR) a = !ctl_m[BROADCAST_BLOCK_BLOCK_BIT];
    else if (ctl_m[HASH_ONLY_BIT] || (ctl_m[HASH_FILTER_BIT] && d[40])) a = htab[h];
    else a = d == sta;
    {RX_DA_I, RX_HASH_I, RX_WAKE_FRAME_I, WAKEUP_FRAME_ENABLE_I} = {d, h, wk, we};
    RX_DA_VALID_I = 1'b1;
    tick;
    RX_DA_VALID_I = 1'b0;
    tick;
    chk(RX_ACCEPT_O === a && RX_REJECT_O === !a && WAKE_O === (wk & we), "verdict");
  endtask
  // Frame model: short length drops pad and FCS
  task automatic frame(input logic [15:0] l, input logic s);
    int k, n;
    set_ctl({23'h0, s, 8'h0});
    in_q.delete();
    out_q.delete();
    eofs = 0;
    sofs = 0;
    flen = l;
    go = 1'b1;
    tick;
    go = 1'b0;
    repeat (3) tick;
    for (n = 0; n < 100 && busy; n++) tick;
    repeat (3) tick;
    k = {in_q[12], in_q[13]};
    k = (s && k < 46) ? 14 + k : in_q.size();
    chk(out_q.size() == k && eofs == 1 && sofs == 1, "frame length");
    for (n = 0; n < k && n < out_q.size(); n++) chk(out_q[n] === in_q[n], "frame byte");
  endtask
  // Transmit model: attempts, late flag and retry error
  task automatic tx_frame(input int nc, input logic lt, input logic dn);
    int   at;
    logic lat, ab, lk;
    {at, lat, ab} = '0;
    lk = lt && !ctl_m[LATE_RETRY_BIT];
    TX_START_I = 1'b1;
    tick;
    TX_START_I = 1'b0;
    while (at < nc && !ab) begin
      repeat (2) tick;
      TX_COLLISION_I = 1'b1;
      TX_LATE_I = lt;
      tick;
      TX_COLLISION_I = 1'b0;
      at++;
      lat = lat | lt;
      ab = lk || ctl_m[SINGLE_ATTEMPT_BIT] || at == 16;
      chk(TX_RETRY_O === !ab && TX_ABANDON_O === ab && TX_STATUS_VALID_O === ab, "tx");
      if (ab) chk(TX_STATUS_O === {lat, !lk}, "tx status");
    end
    if (!ab && dn) begin
      TX_DONE_I = 1'b1;
      tick;
      TX_DONE_I = 1'b0;
      chk(TX_STATUS_VALID_O === 1'b1 && TX_STATUS_O === {lat, 1'b0}, "tx done");
    end
    tick;
  endtask
  // Watchdog, far above the run's length
  initial begin
    repeat (20000) @(posedge CORE_CLK_I);
    mismatches++;
    give_verdict;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {CSR_INDEX_I, CSR_WDATA_I, CSR_WR_I, CSR_RD_I, WAKEUP_FRAME_ENABLE_I} = '0;
    {RX_CHECKSUM_OFFLOAD_ON_I, RX_DA_VALID_I, RX_DA_I, RX_HASH_I, RX_WAKE_FRAME_I} = '0;
    {TX_START_I, TX_COLLISION_I, TX_LATE_I, TX_DONE_I, flen} = '0;
    ftot = 8'd64;
    r = $urandom(99622);
    repeat (6) @(posedge CORE_CLK_I);
    #1 RST_I = 1'b0;
    csr_rd(IDX_MAC_CONTROL, MAC_CONTROL_RESET);
    csr_rd(IDX_ADDR_HIGH, ADDR_HIGH_RESET);
    csr_rd(IDX_ADDR_LOW, ADDR_LOW_RESET);
    csr_rd(IDX_HASH_HIGH, HASH_RESET);
    csr_rd(IDX_HASH_LOW, HASH_RESET);
    csr_wr(4'h6, 32'hffff_ffff);
    csr_rd(4'h6, 32'h0);
    set_ctl(32'hffff_ffff);
    csr_rd(IDX_MAC_CONTROL, MAC_CONTROL_WMASK);
    // Unicast station address, random hash table
    al = $urandom & 32'hffff_fffe;
    ah = $urandom;
    htab = {$urandom, $urandom};
    csr_wr(IDX_ADDR_LOW, al);
    csr_wr(IDX_ADDR_HIGH, ah);
    csr_wr(IDX_HASH_HIGH, htab[63:32]);
    csr_wr(IDX_HASH_LOW, htab[31:0]);
    csr_rd(IDX_ADDR_HIGH, ah & ADDR_HIGH_WMASK);
    sta = {<<8{ah[15:0], al}};
    // All mixes of hash-only, hash select, broadcast block
    for (m = 0; m < 8; m++) begin
      set_ctl({16'h0, m[2], 1'b0, m[1], 1'b0, m[0], 11'h0});
      for (j = 0; j < 8; j++) begin
        r = $urandom;
        da = {r[31:16], $urandom};
        case (j % 4)
          0: da = BROADCAST_BLOCK_ADDR;
          1: da = sta;
          2: da[40] = 1'b0;
          default: da[40] = 1'b1;
        endcase
        da_chk(da, r[5:0], r[6], r[7]);
      end
    end
    frame(16'd20, 1'b1);
    frame(16'd45, 1'b1);
    frame(16'd46, 1'b1);
    frame(16'd20, 1'b0);
    set_ctl(32'h100);
    RX_CHECKSUM_OFFLOAD_ON_I = 1'b1;
    repeat (3) tick;
    chk(CFG_CONFLICT_O === 1'b1, "setup conflict");
    RX_CHECKSUM_OFFLOAD_ON_I = 1'b0;
    set_ctl(32'h400);
    chk(CFG_CONFLICT_O === 1'b0, "setup conflict");
    tx_frame(1, 1'b0, 1'b1);
    tx_frame(0, 1'b0, 1'b1);
    set_ctl(32'h0);
    tx_frame(16, 1'b0, 1'b1);
    tx_frame(1, 1'b1, 1'b1);
    set_ctl(32'h1000);
    tx_frame(2, 1'b1, 1'b1);
    give_verdict;
  end
endmodule // test_mac_filter_retry_pad_control
`default_nettype wire
